// [logic/fsp_pkg.sv]
// shared constants and types of the flash status poller
package fsp_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS    = 25;                          // 40 MHz
    localparam int T_ACC_NS  = 55;                          // address/enable to data
    localparam int RD_CYC    = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_WP_NS   = 35;                          // write pulse width
    localparam int WP_CYC    = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_CYC  = 2;                           // pin synchroniser depth
    localparam logic [3:0] RD_WAIT = 4'(RD_CYC + SYNC_CYC - 1);
    localparam logic [3:0] WP_WAIT = 4'(WP_CYC - 1);
    // ------------------------------------------------------------
    // status bit positions and commands
    // ------------------------------------------------------------
    localparam int BIT_POLL  = 7;                           // data_poll_bit
    localparam int BIT_TOG1  = 6;                           // toggle_bit_one
    localparam int BIT_TOUT  = 5;                           // timeout_fail_bit
    localparam int BIT_WIN   = 3;                           // erase_window_bit
    localparam int BIT_TOG2  = 2;                           // toggle_bit_two
    localparam logic [7:0] CMD_RESET = 8'hf0;
    localparam int AW = 20;
    localparam int DW = 8;

    typedef enum logic [1:0] {K_WRITE, K_READ, K_POLL} fsp_kind_t;
    typedef enum logic [1:0] {ST_IDLE, ST_WR, ST_RD, ST_GAP} fsp_state_t;
    typedef enum logic [1:0] {PH_FIRST, PH_NEXT, PH_RECHECK} fsp_phase_t;

    typedef struct packed {
        fsp_kind_t        kind;
        logic [AW-1:0]    addr;
        logic [DW-1:0]    data;
    } fsp_req_t;

    typedef struct packed {
        logic             ce_n;
        logic             oe_n;
        logic             we_n;
        logic             dq_oe;
        logic [DW-1:0]    dq_out;
        logic [AW-1:0]    addr;
    } fsp_pins_t;
endpackage

// [logic/fsp_poller.sv]
// host-side flash access and toggle-bit status poller
`timescale 1ns/1ps
`default_nettype none

// Operation
// - read status twice, compare toggle bit
// - toggling with timeout bit: recheck toggle
// - still toggling after timeout: fail, reset
// - resumed polling restarts from first read
// - reset command after any timeout failure
// - ignore window bit only if commands fast
// - check window bit around each erase command; the code only latches it into window after every read
// - status reads use the valid address
module fsp_poller
    import fsp_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst,
    // user side
    input  wire logic            req_valid,
    input  wire fsp_req_t        req,
    input  wire logic            abort,
    output var  logic            busy,
    output var  logic            done,
    output var  logic            fail,
    output var  logic [DW-1:0]   rdata,
    output var  logic            window,
    // flash pins
    output var  fsp_pins_t       pins,
    input  wire logic [DW-1:0]   dq_in
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        fsp_state_t      st;
        fsp_phase_t      ph;
        fsp_req_t        rq;
        logic [3:0]      cnt;
        logic [1:0]      reads;
        logic            again;
        logic            failing;
        logic [DW-1:0]   prev;
        logic [DW-1:0]   sync1;
        logic [DW-1:0]   sync2;
        logic            busy;
        logic            done;
        logic            fail;
        logic [DW-1:0]   rdata;
        logic            window;
        fsp_pins_t       pins;
    } fsp_regs_t;

    localparam fsp_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                        dq_oe: 1'b0, dq_out: '0, addr: '0};

    fsp_regs_t s;
    fsp_regs_t next_s;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [DW-1:0] d;
        logic          tog;
        next_s       = s;
        d            = s.sync2;
        tog          = d[BIT_TOG1] ^ s.prev[BIT_TOG1];
        next_s.sync1 = dq_in;                    // first flop, read by sync2 only
        next_s.sync2 = s.sync1;
        next_s.done  = 1'b0;
        case (s.st)
            ST_IDLE: begin
                next_s.pins = PINS_IDLE;
                if (req_valid) begin
                    next_s.rq      = req;
                    next_s.busy    = 1'b1;
                    next_s.fail    = 1'b0;
                    next_s.failing = 1'b0;
                    next_s.ph      = PH_FIRST;
                    next_s.reads   = 2'h0;
                    next_s.pins.addr = req.addr;
                    next_s.pins.ce_n = 1'b0;
                    if (req.kind == K_WRITE) begin
                        next_s.st          = ST_WR;
                        next_s.cnt         = WP_WAIT;
                        next_s.pins.we_n   = 1'b0;
                        next_s.pins.dq_oe  = 1'b1;
                        next_s.pins.dq_out = req.data;
                    end else begin
                        next_s.st        = ST_RD;
                        next_s.cnt       = RD_WAIT;
                        next_s.pins.oe_n = 1'b0;
                    end
                end
            end
            ST_WR: begin
                if (s.cnt != 4'h0) begin
                    next_s.cnt = s.cnt - 4'h1;
                end else begin
                    next_s.pins  = PINS_IDLE;
                    next_s.again = 1'b0;
                    next_s.st    = ST_GAP;
                end
            end
            ST_RD: begin
                if (abort && s.rq.kind == K_POLL) begin
                    next_s.pins = PINS_IDLE;
                    next_s.busy = 1'b0;
                    next_s.st   = ST_IDLE;
                end else if (s.cnt != 4'h0) begin
                    next_s.cnt = s.cnt - 4'h1;
                end else begin
                    // one idle cycle between reads keeps output-enable hold
                    next_s.pins   = PINS_IDLE;
                    next_s.st     = ST_GAP;
                    next_s.again  = 1'b0;
                    next_s.rdata  = d;
                    next_s.window = d[BIT_WIN];
                    next_s.prev   = d;
                    if (s.reads != 2'h3) begin
                        next_s.reads = s.reads + 2'h1;
                    end
                    if (s.rq.kind == K_POLL) begin
                        if (s.ph == PH_FIRST) begin
                            next_s.ph    = PH_NEXT;
                            next_s.again = 1'b1;
                        end else if (!tog) begin
                            next_s.again = 1'b0;
                        end else if (s.ph == PH_RECHECK) begin
                            next_s.failing     = 1'b1;
                            next_s.rq.kind     = K_WRITE;
                            next_s.st          = ST_WR;
                            next_s.cnt         = WP_WAIT;
                            next_s.pins.ce_n   = 1'b0;
                            next_s.pins.we_n   = 1'b0;
                            next_s.pins.dq_oe  = 1'b1;
                            next_s.pins.dq_out = CMD_RESET;
                            next_s.pins.addr   = s.rq.addr;
                        end else begin
                            if (d[BIT_TOUT]) begin
                                next_s.ph = PH_RECHECK;
                            end
                            next_s.again = 1'b1;
                        end
                    end
                end
            end
            ST_GAP: begin
                if (s.again && !abort) begin
                    next_s.st        = ST_RD;
                    next_s.cnt       = RD_WAIT;
                    next_s.pins.ce_n = 1'b0;
                    next_s.pins.oe_n = 1'b0;
                    next_s.pins.addr = s.rq.addr;
                end else begin
                    next_s.st   = ST_IDLE;
                    next_s.busy = 1'b0;
                    next_s.done = !s.again;
                    next_s.fail = s.failing;
                end
            end
            default: begin
                next_s.st   = ST_IDLE;
                next_s.pins = PINS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '{st: ST_IDLE, ph: PH_FIRST, rq: '{kind: K_WRITE, addr: '0, data: '0},
                   cnt: 4'h0, reads: 2'h0, again: 1'b0, failing: 1'b0, prev: '0,
                   sync1: '0, sync2: '0, busy: 1'b0, done: 1'b0, fail: 1'b0,
                   rdata: '0, window: 1'b0, pins: PINS_IDLE};
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state flops
    assign busy   = s.busy;
    assign done   = s.done;
    assign fail   = s.fail;
    assign rdata  = s.rdata;
    assign window = s.window;
    assign pins   = s.pins;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_two_reads: assert property (@(posedge clk) disable iff (rst)
        (done && s.rq.kind == K_POLL) |-> s.reads >= 2'h2)
        else $error("poll finished with fewer than two reads");
    a_recheck_fail: assert property (@(posedge clk) disable iff (rst)
        (s.st == ST_RD && s.cnt == 4'h0 && s.ph == PH_NEXT && !abort &&
         s.rq.kind == K_POLL && (s.sync2[BIT_TOG1] ^ s.prev[BIT_TOG1])
         && s.sync2[BIT_TOUT]) |=> (s.ph == PH_RECHECK && s.st == ST_GAP && !s.failing))
        else $error("timeout bit seen but no recheck");
    a_fail_reset: assert property (@(posedge clk) disable iff (rst)
        (s.failing && !s.pins.we_n) |-> (s.pins.dq_oe && s.pins.dq_out == CMD_RESET))
        else $error("failed poll did not drive reset command");
    a_fail_after_wr: assert property (@(posedge clk) disable iff (rst)
        $rose(s.failing) |-> (!s.pins.we_n) [*2] ##1 s.pins.we_n ##1 (done && fail))
        else $error("failure not reported after reset write");
    a_abort_idle: assert property (@(posedge clk) disable iff (rst)
        (abort && s.st == ST_RD && s.rq.kind == K_POLL) |=>
            (s.st == ST_IDLE && !busy && pins.oe_n))
        else $error("abort did not end polling");
    a_read_addr: assert property (@(posedge clk) disable iff (rst)
        !pins.oe_n |-> (pins.addr == s.rq.addr && !pins.ce_n && pins.we_n))
        else $error("status read at wrong address or with write low");
    a_read_len: assert property (@(posedge clk) disable iff (rst)
        ($fell(pins.oe_n) && !abort) |-> (!pins.oe_n) [*2])
        else $error("read strobe too short");
    a_window_bit: assert property (@(posedge clk) disable iff (rst)
        $rose(s.st == ST_GAP) && $past(s.st) == ST_RD |-> window == s.prev[BIT_WIN])
        else $error("window bit not taken from last read");

endmodule // fsp_poller

`default_nettype wire

// [tb/fsp_flash_model.sv]
// behavioural flash device answering status and array reads
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_model
    import fsp_pkg::*;
(
    input  wire logic          clk,
    input  wire fsp_pins_t     pins,
    input  wire logic          start,
    input  wire logic [7:0]    n_tog,
    input  wire logic [7:0]    n_tout,
    input  wire logic [DW-1:0] arr,
    input  wire logic          win,
    output var  logic [DW-1:0] dq
);
    logic [7:0]    cnt    = 8'hff;
    logic          oe_q   = 1'b1;
    logic          halted = 1'b0;
    logic [DW-1:0] last   = 8'h00;

    // -----------------------------------------------------------
    // count finished reads, reset command ends the operation
    // -----------------------------------------------------------
    always @(posedge clk) begin
        oe_q <= pins.oe_n;
        if (start) begin
            cnt <= 8'h00;
            halted <= 1'b0;
        end else if (pins.oe_n && !oe_q && cnt != 8'hff) begin
            cnt <= cnt + 8'h01;
        end
        if (!pins.we_n && !pins.ce_n && pins.dq_out == CMD_RESET) begin
            halted <= 1'b1;
        end
        if (!pins.ce_n && !pins.oe_n) begin
            last <= dq;
        end
    end

    // -----------------------------------------------------------
    // released bus shows inverse of last value
    // -----------------------------------------------------------
    always_comb begin
        dq = '0;
        if (pins.ce_n || pins.oe_n) begin
            dq = ~last;
        end else if (halted || cnt >= n_tog) begin
            dq = arr;
        end else begin
            dq[BIT_TOG1] = cnt[0];                 // toggles each read
            dq[BIT_TOG2] = cnt[0];
            dq[BIT_TOUT] = (cnt >= n_tout);
            dq[BIT_WIN]  = win;
        end
    end
endmodule // fsp_flash_model
`default_nettype wire

// [tb/fsp_poller_test.sv]
// self-checking bench of the flash status poller
`timescale 1ns/1ps
`default_nettype none
module fsp_poller_test
    import fsp_pkg::*;
;
    typedef struct packed {logic chk; logic fail; logic [DW-1:0] rdata; logic win;} fsp_exp_t;
    logic          clk = 0, rst = 1, req_valid = 0, abort = 0, start = 0, win = 0;
    logic          busy, done, fail, window;
    logic [DW-1:0] rdata, dq, arr = '0, wd = '0, wr_seen = '0;
    logic [7:0]    n_tog = 0, n_tout = 0;
    fsp_req_t      req = '0;
    fsp_pins_t     pins;
    fsp_exp_t      q[$];
    int            error_cnt = 0, checks_done = 0;

    always #12.5 clk = ~clk;

    // capture the byte the poller drives while its write strobe is low
    always @(negedge clk) begin
        if (pins.we_n === 1'b0) begin
            wr_seen = pins.dq_out;
        end
    end

    fsp_poller fsp_poller_inst (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
        .abort(abort), .busy(busy), .done(done), .fail(fail), .rdata(rdata),
        .window(window), .pins(pins), .dq_in(dq));
    fsp_flash_model fsp_flash_model_inst (.clk(clk), .pins(pins), .start(start),
        .n_tog(n_tog), .n_tout(n_tout), .arr(arr), .win(win), .dq(dq));

    task automatic check(string what, logic [DW-1:0] seen, logic [DW-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // compare each completion with the oldest note
    // ---------------------------------------------------------------
    always @(negedge clk) begin
        fsp_exp_t e;
        if (done === 1'b1) begin
            e = q.size() > 0 ? q.pop_front() : '1;
            check("fail", {7'h0, fail}, {7'h0, e.fail});
            if (e.chk) begin
                check("rdata", rdata, e.rdata);
                check("window", {7'h0, window}, {7'h0, e.win});
            end
        end
    end

    task automatic arm(logic [7:0] t, logic [7:0] o);
        @(negedge clk);
        n_tog = t;
        n_tout = o;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
    endtask

    task automatic issue(fsp_kind_t k, logic [DW-1:0] d);
        @(negedge clk);
        req_valid = 1'b1;
        req = '{k, 20'h01000, d};
        @(negedge clk);
        req_valid = 1'b0;
    endtask

    task automatic op(fsp_kind_t k, logic [DW-1:0] d, fsp_exp_t e);
        int n;
        q.push_back(e);
        issue(k, d);
        n = 0;
        while (done !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        if (n == 500) check("done wait", 8'h00, 8'h01);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'hee50));
        repeat (5) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            arr = 8'($urandom) & 8'hbf;
            arm(8'(i), 8'(2 + $urandom % 100));
            op(K_POLL, 8'h00, '{1'b1, 1'b0, arr, arr[BIT_WIN]});
        end
        $display("test poll_ok done");
        for (int i = 0; i < 3; i++) begin
            arm(8'hfe, 8'(1 + $urandom % 8));
            op(K_POLL, 8'h00, '{1'b0, 1'b1, 8'h00, 1'b0});
            check("reset cmd", wr_seen, CMD_RESET);
            op(K_READ, 8'h00, '{1'b1, 1'b0, arr, arr[BIT_WIN]});
        end
        $display("test poll_fail done");
        arm(8'hfe, 8'hc8);
        win = 1'b1;
        op(K_READ, 8'h00, '{1'b1, 1'b0, 8'h08, 1'b1});
        win = 1'b0;
        op(K_READ, 8'h00, '{1'b1, 1'b0, 8'h44, 1'b0});
        wd = 8'($urandom) & 8'h7f;
        op(K_WRITE, wd, '{1'b0, 1'b0, 8'h00, 1'b0});
        check("wdata", wr_seen, wd);
        $display("test window_write done");
        arm(8'hfe, 8'hc8);
        issue(K_POLL, 8'h00);
        repeat (20) @(negedge clk);
        abort = 1'b1;
        @(negedge clk);
        abort = 1'b0;
        repeat (3) @(negedge clk);
        check("busy", {7'h0, busy}, 8'h00);
        arm(8'h00, 8'hc8);
        op(K_POLL, 8'h00, '{1'b1, 1'b0, arr, arr[BIT_WIN]});
        $display("test abort done");
        // reset in the middle of a poll, then a fresh poll
        arm(8'hfe, 8'hc8);
        issue(K_POLL, 8'h00);
        repeat (9) @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        check("busy rst", {7'h0, busy}, 8'h00);
        check("rdata rst", rdata, 8'h00);
        check("strobe rst", {7'h0, pins.oe_n}, 8'h01);
        arm(8'h00, 8'hc8);
        op(K_POLL, 8'h00, '{1'b1, 1'b0, arr, arr[BIT_WIN]});
        $display("test reset done");
        end_of_test;
    end

    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        #1000000;
        error_cnt++;
        end_of_test;
    end
endmodule // fsp_poller_test
`default_nettype wire
